//--- src/bfu_bit_unit.sv
// Bit manipulation, bit test and machine control execution unit with its own status register.
// Assumes the decoder holds a request until busy is low and that extAck answers external accesses.
`timescale 1ns/1ps
`include "bfu_cfg.svh"
module bfu_bit_unit #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire bfu_pkg::bfu_req_t req,
    input wire logic extAck,
    output logic busy,
    output bfu_pkg::bfu_rsp_t rsp,
    output logic [7:0] statusRegister
);
    if (DATA_W != 8) begin : g_bad_width
        $error("bfu_bit_unit serves an 8-bit datapath only");
    end

    bfu_pkg::bfu_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    bfu_pkg::bfu_rsp_t rsp_r, rsp_nxt;
    logic [7:0] status_register_r, status_register_nxt;
    logic accept;
    logic [7:0] d;
    logic [3:0] memTotal;

    assign accept = req.valid && !busy_r;
    assign d = req.opData;

    always_comb begin
        memTotal = {1'b0, req.memCycles};
        if (memTotal == 4'h0) begin
            memTotal = `BFU_ALU_CYCLES;
        end
        if (req.memTarget == bfu_pkg::BFU_MEM_SRAM) begin
            memTotal = memTotal + `BFU_SRAM_EXTRA;
        end
    end

    always_comb begin
        rsp_nxt = '0;
        status_register_nxt = status_register_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        case (state_r)
            bfu_pkg::BFU_ST_IDLE: begin
                if (accept) begin
                    rsp_nxt.valid = 1'b1;
                    case (req.op)
                        bfu_pkg::BFU_OP_ROTATE_LEFT_CARRY: begin
                            rsp_nxt.regWe = 1'b1;
                            rsp_nxt.regData = {d[6:0], status_register_r[`BFU_FLAG_C]};
                            status_register_nxt[`BFU_FLAG_C] = d[7];
                            status_register_nxt[`BFU_FLAG_Z] = (rsp_nxt.regData == 8'h00);
                            status_register_nxt[`BFU_FLAG_N] = d[6];
                            status_register_nxt[`BFU_FLAG_V] = d[6] ^ d[7];
                            status_register_nxt[`BFU_FLAG_H] = d[3];
                        end
                        bfu_pkg::BFU_OP_ROTATE_RIGHT_CARRY: begin
                            rsp_nxt.regWe = 1'b1;
                            rsp_nxt.regData = {status_register_r[`BFU_FLAG_C], d[7:1]};
                            status_register_nxt[`BFU_FLAG_C] = d[0];
                            status_register_nxt[`BFU_FLAG_Z] = (rsp_nxt.regData == 8'h00);
                            status_register_nxt[`BFU_FLAG_N] = status_register_r[`BFU_FLAG_C];
                            status_register_nxt[`BFU_FLAG_V] = status_register_r[`BFU_FLAG_C] ^ d[0];
                        end
                        bfu_pkg::BFU_OP_ARITH_SHIFT_RIGHT: begin
                            rsp_nxt.regWe = 1'b1;
                            rsp_nxt.regData = {d[7], d[7:1]};
                            status_register_nxt[`BFU_FLAG_C] = d[0];
                            status_register_nxt[`BFU_FLAG_Z] = (rsp_nxt.regData == 8'h00);
                            status_register_nxt[`BFU_FLAG_N] = d[7];
                            status_register_nxt[`BFU_FLAG_V] = d[7] ^ d[0];
                        end
                        bfu_pkg::BFU_OP_NIBBLE_SWAP: begin
                            rsp_nxt.regWe = 1'b1;
                            rsp_nxt.regData = {d[3:0], d[7:4]};
                        end
                        bfu_pkg::BFU_OP_IO_BIT_SET: begin
                            rsp_nxt.ioWe = 1'b1;
                            rsp_nxt.ioData = req.ioData | (8'h01 << req.bitSel);
                        end
                        bfu_pkg::BFU_OP_IO_BIT_CLEAR: begin
                            rsp_nxt.ioWe = 1'b1;
                            rsp_nxt.ioData = req.ioData & ~(8'h01 << req.bitSel);
                        end
                        bfu_pkg::BFU_OP_BIT_TO_TRANSFER_FLAG: begin
                            status_register_nxt[`BFU_FLAG_T] = d[req.bitSel];
                        end
                        bfu_pkg::BFU_OP_TRANSFER_FLAG_TO_BIT: begin
                            rsp_nxt.regWe = 1'b1;
                            rsp_nxt.regData = d;
                            rsp_nxt.regData[req.bitSel] = status_register_r[`BFU_FLAG_T];
                        end
                        bfu_pkg::BFU_OP_GENERIC_FLAG_SET: status_register_nxt[req.bitSel] = 1'b1;
                        bfu_pkg::BFU_OP_GENERIC_FLAG_CLEAR: status_register_nxt[req.bitSel] = 1'b0;
                        bfu_pkg::BFU_OP_OVERFLOW_FLAG_SET: status_register_nxt[`BFU_FLAG_V] = 1'b1;
                        bfu_pkg::BFU_OP_OVERFLOW_FLAG_CLEAR: status_register_nxt[`BFU_FLAG_V] = 1'b0;
                        bfu_pkg::BFU_OP_HALF_CARRY_SET: status_register_nxt[`BFU_FLAG_H] = 1'b1;
                        bfu_pkg::BFU_OP_HALF_CARRY_CLEAR: status_register_nxt[`BFU_FLAG_H] = 1'b0;
                        bfu_pkg::BFU_OP_SIGN_FLAG_SET: status_register_nxt[`BFU_FLAG_S] = 1'b1;
                        bfu_pkg::BFU_OP_SIGN_FLAG_CLEAR: status_register_nxt[`BFU_FLAG_S] = 1'b0;
                        bfu_pkg::BFU_OP_CARRY_SET: status_register_nxt[`BFU_FLAG_C] = 1'b1;
                        bfu_pkg::BFU_OP_CARRY_CLEAR: status_register_nxt[`BFU_FLAG_C] = 1'b0;
                        bfu_pkg::BFU_OP_ZERO_SET: status_register_nxt[`BFU_FLAG_Z] = 1'b1;
                        bfu_pkg::BFU_OP_ZERO_CLEAR: status_register_nxt[`BFU_FLAG_Z] = 1'b0;
                        bfu_pkg::BFU_OP_NEG_SET: status_register_nxt[`BFU_FLAG_N] = 1'b1;
                        bfu_pkg::BFU_OP_NEG_CLEAR: status_register_nxt[`BFU_FLAG_N] = 1'b0;
                        bfu_pkg::BFU_OP_INT_ENABLE: status_register_nxt[`BFU_FLAG_I] = 1'b1;
                        bfu_pkg::BFU_OP_INT_DISABLE: status_register_nxt[`BFU_FLAG_I] = 1'b0;
                        bfu_pkg::BFU_OP_TFLAG_SET: status_register_nxt[`BFU_FLAG_T] = 1'b1;
                        bfu_pkg::BFU_OP_TFLAG_CLEAR: status_register_nxt[`BFU_FLAG_T] = 1'b0;
                        bfu_pkg::BFU_OP_BREAK: rsp_nxt.breakReq = 1'b1;
                        bfu_pkg::BFU_OP_SLEEP: rsp_nxt.sleepReq = 1'b1;
                        bfu_pkg::BFU_OP_WATCHDOG_KICK: rsp_nxt.wdKick = 1'b1;
                        bfu_pkg::BFU_OP_MEM_ACCESS: begin
                            // External timing is not bounded, so completion waits for the bus.
                            if (req.memTarget == bfu_pkg::BFU_MEM_EXTERNAL) begin
                                rsp_nxt.valid = 1'b0;
                                state_nxt = bfu_pkg::BFU_ST_EXT;
                                busy_nxt = 1'b1;
                            end else if (memTotal > `BFU_ALU_CYCLES) begin
                                rsp_nxt.valid = 1'b0;
                                state_nxt = bfu_pkg::BFU_ST_COUNT;
                                cnt_nxt = memTotal - `BFU_ALU_CYCLES;
                                busy_nxt = 1'b1;
                            end else begin
                                rsp_nxt.memDone = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            bfu_pkg::BFU_ST_COUNT: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.memDone = 1'b1;
                    state_nxt = bfu_pkg::BFU_ST_IDLE;
                    busy_nxt = 1'b0;
                end
            end
            bfu_pkg::BFU_ST_EXT: begin
                if (extAck) begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.memDone = 1'b1;
                    state_nxt = bfu_pkg::BFU_ST_IDLE;
                    busy_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = bfu_pkg::BFU_ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= bfu_pkg::BFU_ST_IDLE;
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            rsp_r <= '0;
            status_register_r <= `BFU_STATUS_REGISTER_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            rsp_r <= rsp_nxt;
            status_register_r <= status_register_nxt;
        end
    end

    assign busy = busy_r;
    assign rsp = rsp_r;
    assign statusRegister = status_register_r;

    chk_rotl_result: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_ROTATE_LEFT_CARRY |=>
        rsp.regWe && rsp.regData == {$past(d[6:0]), $past(status_register_r[0])} && status_register_r[0] == $past(d[7]))
        else $error("rotate left result or carry wrong");
    chk_rotr_result: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_ROTATE_RIGHT_CARRY |=>
        rsp.regData == {$past(status_register_r[0]), $past(d[7:1])} && status_register_r[0] == $past(d[0])
        && status_register_r[5] == $past(status_register_r[5]))
        else $error("rotate right result, carry or half carry wrong");
    chk_io_set: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_IO_BIT_SET |=>
        rsp.ioWe && rsp.ioData[$past(req.bitSel)] && $stable(status_register_r))
        else $error("I/O bit set failed or touched flags");
    chk_io_clear: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_IO_BIT_CLEAR |=>
        rsp.ioWe && !rsp.ioData[$past(req.bitSel)] && $stable(status_register_r))
        else $error("I/O bit clear failed or touched flags");
    chk_tflag_store: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_BIT_TO_TRANSFER_FLAG |=>
        status_register_r[6] == $past(d[req.bitSel]) && status_register_r[5:0] == $past(status_register_r[5:0]))
        else $error("transfer flag store wrong");
    chk_tflag_load: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_TRANSFER_FLAG_TO_BIT |=>
        rsp.regData[$past(req.bitSel)] == $past(status_register_r[6]) && $stable(status_register_r))
        else $error("transfer flag load wrong");
    chk_overflow_set: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_OVERFLOW_FLAG_SET |=>
        status_register_r == ($past(status_register_r) | 8'h08))
        else $error("overflow set altered the wrong flags");
    chk_half_clear: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_HALF_CARRY_CLEAR |=>
        status_register_r == ($past(status_register_r) & 8'hdf))
        else $error("half carry clear altered the wrong flags");
    chk_sign_set: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_SIGN_FLAG_SET |=>
        status_register_r == ($past(status_register_r) | 8'h10))
        else $error("sign set altered the wrong flags");
    chk_sram_extra: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_MEM_ACCESS && req.memTarget == bfu_pkg::BFU_MEM_SRAM
        && req.memCycles == 3'h2 |=> !rsp.memDone ##1 !rsp.memDone ##1 rsp.memDone)
        else $error("internal SRAM access did not take one extra cycle");
    chk_swap_flags: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_NIBBLE_SWAP |=>
        rsp.regData == {$past(d[3:0]), $past(d[7:4])} && $stable(status_register_r))
        else $error("nibble swap wrong");
    chk_sleep_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        accept && req.op == bfu_pkg::BFU_OP_SLEEP ##1 !(accept && req.op == bfu_pkg::BFU_OP_SLEEP)
        |-> rsp.valid && rsp.sleepReq ##1 !rsp.sleepReq)
        else $error("sleep request not a single cycle");
endmodule

//--- src/bfu_cfg.svh
// Constants for the bit and flag instruction unit: flag positions, reset values, timing counts.
// Assumes the status register layout C,Z,N,V,S,H,T,I from bit 0 upward.
// Summary of operation
// - Rotate left through carry: bit 0 from carry, carry from bit 7; Z,C,N,V,H; one cycle.
// - Rotate right through carry: bit 7 from carry, carry from bit 0; Z,C,N,V; one cycle.
// - I/O bit set forces the selected I/O bit high, flags unchanged, one cycle.
// - I/O bit clear forces the selected I/O bit low, flags unchanged, one cycle.
// - Bit to transfer flag copies the selected register bit into T only, one cycle.
// - Transfer flag to bit copies T into the selected register bit, no flags, one cycle.
// - Overflow set writes V high, overflow clear writes V low; only V, one cycle.
// - Half carry set writes H high, half carry clear writes H low; only H, one cycle.
// - Sign flag set writes S high, sign flag clear writes S low; only S, one cycle.
// - Data memory cycle counts hold for internal memory only; external accesses may run longer.
// - An access to internal static RAM takes one cycle more than its listed count.
`ifndef BFU_CFG_SVH
`define BFU_CFG_SVH
`define BFU_FLAG_C 3'h0
`define BFU_FLAG_Z 3'h1
`define BFU_FLAG_N 3'h2
`define BFU_FLAG_V 3'h3
`define BFU_FLAG_S 3'h4
`define BFU_FLAG_H 3'h5
`define BFU_FLAG_T 3'h6
`define BFU_FLAG_I 3'h7
`define BFU_STATUS_REGISTER_RESET 8'h00
`define BFU_SRAM_EXTRA 4'h1
`define BFU_ALU_CYCLES 4'h1
`endif

//--- src/bfu_pkg.sv
// Types shared by the bit and flag instruction unit and its surroundings.
// Assumes the decoder delivers one instruction per request with operands already fetched.
package bfu_pkg;
    typedef enum logic [5:0] {
        BFU_OP_NOP, BFU_OP_ROTATE_LEFT_CARRY, BFU_OP_ROTATE_RIGHT_CARRY,
        BFU_OP_ARITH_SHIFT_RIGHT, BFU_OP_NIBBLE_SWAP, BFU_OP_GENERIC_FLAG_SET,
        BFU_OP_GENERIC_FLAG_CLEAR, BFU_OP_IO_BIT_SET, BFU_OP_IO_BIT_CLEAR,
        BFU_OP_BIT_TO_TRANSFER_FLAG, BFU_OP_TRANSFER_FLAG_TO_BIT,
        BFU_OP_OVERFLOW_FLAG_SET, BFU_OP_OVERFLOW_FLAG_CLEAR,
        BFU_OP_HALF_CARRY_SET, BFU_OP_HALF_CARRY_CLEAR,
        BFU_OP_SIGN_FLAG_SET, BFU_OP_SIGN_FLAG_CLEAR,
        BFU_OP_CARRY_SET, BFU_OP_CARRY_CLEAR, BFU_OP_ZERO_SET, BFU_OP_ZERO_CLEAR,
        BFU_OP_NEG_SET, BFU_OP_NEG_CLEAR, BFU_OP_INT_ENABLE, BFU_OP_INT_DISABLE,
        BFU_OP_TFLAG_SET, BFU_OP_TFLAG_CLEAR, BFU_OP_BREAK, BFU_OP_SLEEP,
        BFU_OP_WATCHDOG_KICK, BFU_OP_MEM_ACCESS
    } bfu_op_t;

    typedef enum logic [1:0] {
        BFU_MEM_INTERNAL = 2'h0,
        BFU_MEM_SRAM = 2'h1,
        BFU_MEM_EXTERNAL = 2'h2
    } bfu_mem_t;

    // Gray coded along idle, counting, external wait.
    typedef enum logic [1:0] {
        BFU_ST_IDLE = 2'h0,
        BFU_ST_COUNT = 2'h1,
        BFU_ST_EXT = 2'h3
    } bfu_state_t;

    typedef struct packed {
        logic valid;
        bfu_op_t op;
        logic [7:0] opData;
        logic [7:0] ioData;
        logic [2:0] bitSel;
        logic [2:0] memCycles;
        bfu_mem_t memTarget;
    } bfu_req_t;

    typedef struct packed {
        logic valid;
        logic regWe;
        logic [7:0] regData;
        logic ioWe;
        logic [7:0] ioData;
        logic memDone;
        logic breakReq;
        logic sleepReq;
        logic wdKick;
    } bfu_rsp_t;
endpackage

//--- tb/bfu_bit_unit_bench.sv
// Self-checking bench for the bit and flag instruction unit.
// Assumes a result shows just after the edge that takes its request and extAck is heard only in external wait.
`timescale 1ns/1ps
`define BFU_CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module bfu_bit_unit_bench;
    typedef struct {
        bfu_pkg::bfu_op_t op;
        logic [7:0] d;
        logic [7:0] io;
        logic [2:0] b;
        logic [7:0] r;
        logic [7:0] sr;
        logic [4:0] fl;
    } bfu_row_t;
    logic clk;
    logic rst_b;
    bfu_pkg::bfu_req_t req;
    logic extAck;
    logic busy;
    bfu_pkg::bfu_rsp_t rsp;
    logic [7:0] statusRegister;
    int miscompares;
    int nTests;
    bfu_row_t rows[$];
    bfu_row_t x;

    bfu_bit_unit #(.DATA_W(8)) i_dut (
        .clk(clk),
        .rst_b(rst_b),
        .req(req),
        .extAck(extAck),
        .busy(busy),
        .rsp(rsp),
        .statusRegister(statusRegister)
    );

    function automatic void addRow(bfu_pkg::bfu_op_t op, logic [7:0] d, logic [7:0] io,
            logic [2:0] b, logic [7:0] r, logic [7:0] sr, logic [4:0] fl);
        bfu_row_t y;
        y = '{op, d, io, b, r, sr, fl};
        rows.push_back(y);
    endfunction

    // Flag-only rows produce no register, I/O or control pulse.
    function automatic void fRow(bfu_pkg::bfu_op_t op, logic [7:0] sr);
        addRow(op, 8'h00, 8'h00, 3'h0, 8'h00, sr, 5'h00);
    endfunction

    task automatic test_done();
        if (miscompares == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The busy window also carries a refused overflow clear that must leave no trace.
    task automatic memCheck(input logic [2:0] cyc, input bfu_pkg::bfu_mem_t tgt, input int ackAt,
            input int expT);
        logic [7:0] sr0;
        int n;
        sr0 = statusRegister;
        req.op = bfu_pkg::BFU_OP_MEM_ACCESS;
        req.memCycles = cyc;
        req.memTarget = tgt;
        req.valid = 1'b1;
        extAck = 1'b1;
        @(posedge clk);
        #1;
        n = 1;
        while (n < 20 && rsp.memDone !== 1'b1) begin
            `BFU_CHK("busy", 2'b10, {busy, rsp.valid})
            req.op = bfu_pkg::BFU_OP_OVERFLOW_FLAG_CLEAR;
            extAck = (n == ackAt);
            @(posedge clk);
            #1;
            n++;
        end
        req.valid = 1'b0;
        extAck = 1'b0;
        `BFU_CHK("latency", expT, n)
        `BFU_CHK("done", 2'b01, {busy, rsp.valid})
        `BFU_CHK("refused", sr0, statusRegister)
        // An edge passes with valid low, so back to back calls never merge their requests.
        @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        extAck = 1'b0;
        miscompares = 0;
        nTests = 0;
        fRow(bfu_pkg::BFU_OP_HALF_CARRY_SET, 8'h20);
        fRow(bfu_pkg::BFU_OP_HALF_CARRY_CLEAR, 8'h00);
        fRow(bfu_pkg::BFU_OP_OVERFLOW_FLAG_SET, 8'h08);
        fRow(bfu_pkg::BFU_OP_OVERFLOW_FLAG_CLEAR, 8'h00);
        fRow(bfu_pkg::BFU_OP_SIGN_FLAG_SET, 8'h10);
        fRow(bfu_pkg::BFU_OP_SIGN_FLAG_CLEAR, 8'h00);
        fRow(bfu_pkg::BFU_OP_CARRY_SET, 8'h01);
        fRow(bfu_pkg::BFU_OP_ZERO_SET, 8'h03);
        fRow(bfu_pkg::BFU_OP_NEG_SET, 8'h07);
        fRow(bfu_pkg::BFU_OP_INT_ENABLE, 8'h87);
        fRow(bfu_pkg::BFU_OP_TFLAG_SET, 8'hc7);
        addRow(bfu_pkg::BFU_OP_GENERIC_FLAG_CLEAR, 8'h00, 8'h00, 3'h7, 8'h00, 8'h47, 5'h00);
        addRow(bfu_pkg::BFU_OP_GENERIC_FLAG_SET, 8'h00, 8'h00, 3'h4, 8'h00, 8'h57, 5'h00);
        fRow(bfu_pkg::BFU_OP_CARRY_CLEAR, 8'h56);
        fRow(bfu_pkg::BFU_OP_ZERO_CLEAR, 8'h54);
        fRow(bfu_pkg::BFU_OP_NEG_CLEAR, 8'h50);
        fRow(bfu_pkg::BFU_OP_TFLAG_CLEAR, 8'h10);
        fRow(bfu_pkg::BFU_OP_INT_DISABLE, 8'h10);
        addRow(bfu_pkg::BFU_OP_GENERIC_FLAG_CLEAR, 8'h00, 8'h00, 3'h4, 8'h00, 8'h00, 5'h00);
        addRow(bfu_pkg::BFU_OP_ROTATE_LEFT_CARRY, 8'h81, 8'h00, 3'h0, 8'h02, 8'h09, 5'h10);
        addRow(bfu_pkg::BFU_OP_ROTATE_LEFT_CARRY, 8'h02, 8'h00, 3'h0, 8'h05, 8'h00, 5'h10);
        addRow(bfu_pkg::BFU_OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h00, 3'h0, 8'h00, 8'h0b, 5'h10);
        fRow(bfu_pkg::BFU_OP_HALF_CARRY_SET, 8'h2b);
        addRow(bfu_pkg::BFU_OP_ROTATE_RIGHT_CARRY, 8'h00, 8'h00, 3'h0, 8'h80, 8'h2c, 5'h10);
        addRow(bfu_pkg::BFU_OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 3'h0, 8'hc0, 8'h25, 5'h10);
        addRow(bfu_pkg::BFU_OP_ARITH_SHIFT_RIGHT, 8'h01, 8'h00, 3'h0, 8'h00, 8'h2b, 5'h10);
        addRow(bfu_pkg::BFU_OP_NIBBLE_SWAP, 8'ha5, 8'h00, 3'h0, 8'h5a, 8'h2b, 5'h10);
        addRow(bfu_pkg::BFU_OP_BIT_TO_TRANSFER_FLAG, 8'h08, 8'h00, 3'h3, 8'h00, 8'h6b, 5'h00);
        addRow(bfu_pkg::BFU_OP_TRANSFER_FLAG_TO_BIT, 8'h00, 8'h00, 3'h7, 8'h80, 8'h6b, 5'h10);
        addRow(bfu_pkg::BFU_OP_BIT_TO_TRANSFER_FLAG, 8'hf7, 8'h00, 3'h3, 8'h00, 8'h2b, 5'h00);
        addRow(bfu_pkg::BFU_OP_TRANSFER_FLAG_TO_BIT, 8'hff, 8'h00, 3'h0, 8'hfe, 8'h2b, 5'h10);
        addRow(bfu_pkg::BFU_OP_IO_BIT_SET, 8'h00, 8'h00, 3'h3, 8'h08, 8'h2b, 5'h08);
        addRow(bfu_pkg::BFU_OP_IO_BIT_SET, 8'h00, 8'hff, 3'h7, 8'hff, 8'h2b, 5'h08);
        addRow(bfu_pkg::BFU_OP_IO_BIT_CLEAR, 8'h00, 8'hff, 3'h0, 8'hfe, 8'h2b, 5'h08);
        addRow(bfu_pkg::BFU_OP_IO_BIT_CLEAR, 8'h00, 8'h80, 3'h7, 8'h00, 8'h2b, 5'h08);
        addRow(bfu_pkg::BFU_OP_BREAK, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2b, 5'h04);
        addRow(bfu_pkg::BFU_OP_SLEEP, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2b, 5'h02);
        addRow(bfu_pkg::BFU_OP_WATCHDOG_KICK, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2b, 5'h01);
        fRow(bfu_pkg::BFU_OP_NOP, 8'h2b);
        repeat (10) @(posedge clk);
        #1;
        `BFU_CHK("reset", 11'h000, {busy, rsp.valid, rsp.memDone, statusRegister})
        rst_b = 1'b1;
        // Rows go in back to back, so each result is checked while the next row is presented.
        for (int m = 0; m < rows.size() + 1; m++) begin
            req.valid = (m < rows.size());
            if (m < rows.size()) begin
                req.op = rows[m].op;
                req.opData = rows[m].d;
                req.ioData = rows[m].io;
                req.bitSel = rows[m].b;
            end
            if (m >= 1) begin
                x = rows[m - 1];
                `BFU_CHK("valid", 2'b10, {rsp.valid, rsp.memDone})
                `BFU_CHK("status", x.sr, statusRegister)
                `BFU_CHK("pulses", x.fl, {rsp.regWe, rsp.ioWe, rsp.breakReq, rsp.sleepReq,
                    rsp.wdKick})
                if (x.fl[4]) `BFU_CHK("regData", x.r, rsp.regData)
                if (x.fl[3]) `BFU_CHK("ioData", x.r, rsp.ioData)
            end
            @(posedge clk);
            #1;
        end
        `BFU_CHK("idle", 1'b0, rsp.valid)
        memCheck(3'h0, bfu_pkg::BFU_MEM_INTERNAL, 0, 1);
        memCheck(3'h5, bfu_pkg::BFU_MEM_INTERNAL, 0, 5);
        memCheck(3'h2, bfu_pkg::BFU_MEM_SRAM, 0, 3);
        memCheck(3'h7, bfu_pkg::BFU_MEM_SRAM, 0, 8);
        memCheck(3'h0, bfu_pkg::BFU_MEM_EXTERNAL, 4, 5);
        // A reset landing on a live result must clear it at once, not at the next edge.
        req.op = bfu_pkg::BFU_OP_SIGN_FLAG_SET;
        req.valid = 1'b1;
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        `BFU_CHK("sign", 9'h13b, {rsp.valid, statusRegister})
        rst_b = 1'b0;
        #1;
        `BFU_CHK("midReset", 10'h000, {busy, rsp.valid, statusRegister})
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        `BFU_CHK("afterReset", 10'h000, {busy, rsp.valid, statusRegister})
        test_done();
    end
endmodule
